//--- inc/tcv_params.svh
`ifndef TCV_PARAMS_SVH
`define TCV_PARAMS_SVH

// ----------------------------------------------------------------------
// Register byte addresses on the APB side.
// ----------------------------------------------------------------------
`define TCV_ADDR_SC 12'h000
`define TCV_ADDR_VH 12'h004
`define TCV_ADDR_VL 12'h008
`define TCV_ADDR_MODE 12'h00c
`define TCV_ADDR_OUT 12'h010

// ----------------------------------------------------------------------
// Field positions of the status/control byte and the mode byte.
// ----------------------------------------------------------------------
`define TCV_SC_FLAG 7
`define TCV_SC_IE 6
`define TCV_SC_MSB 5
`define TCV_SC_MSA 4
`define TCV_SC_EDGE_LEVEL_SEL_HI 3
`define TCV_SC_EDGE_LEVEL_SEL_LO 2
`define TCV_MODE_WRITE_PROTECT_DISABLE 0
`define TCV_MODE_FEN 1
`define TCV_MODE_HALT 2
`define TCV_MODE_CAPTEST 3
`define TCV_MODE_DECAP 4

// ----------------------------------------------------------------------
// Reset values and codes.
// ----------------------------------------------------------------------
`define TCV_WRITE_PROTECT_DISABLE_RESET 1'b1
`define TCV_ELS_OFF 2'h0
`define TCV_ELS_TOGGLE 2'h1
`define TCV_ELS_CLEAR 2'h2
`define TCV_ELS_SET 2'h3
`define TCV_MS_INPUT 2'h0
`define TCV_MS_COMPARE 2'h1
// Counter value at which a completed write pair is moved into the channel value.
`define TCV_UPDATE_POINT 16'h0000

`endif

//--- inc/tcv_pkg.sv
package tcv_pkg;

	// Byte-pair coherency state shared by the read and write latches.
	typedef enum logic [2:0] {
		TCV_IDLE = 3'h1,
		TCV_HIGH = 3'h2,
		TCV_LOW = 3'h4
	} tcv_pair_t;

endpackage

//--- logic/tcv_pin_sync.sv
`timescale 1ns/1ps

// Three-stage synchroniser: a change counts once stages two and three agree.
module tcv_pin_sync (
	input wire logic clk,
	input wire logic rst,
	input wire logic pinIn,
	output logic pinOut
);

	typedef struct packed {
		logic [2:0] stage;
		logic level;
	} tcv_sync_t;

	tcv_sync_t state_reg;
	tcv_sync_t state_next;

	// Only the second stage reads the first one.
	always_comb begin
		state_next = state_reg;
		state_next.stage = {state_reg.stage[1:0], pinIn};
		if (state_reg.stage[1] == state_reg.stage[2]) begin
			state_next.level = state_reg.stage[2];
		end
	end

	// Register the stages.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign pinOut = state_reg.level;

endmodule // tcv_pin_sync

//--- logic/tcv_channel.sv
// The placing of the registers and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
`include "tcv_params.svh"

// Notes on behaviour
// - A channel event sets the flag at bit 7.
// - Flag clears only after a read seeing it set, then a zero write.
// - Writing one to the flag leaves it unchanged.
// - An event between clearing read and write keeps the flag set.
// - Bit 6 enables the channel interrupt; zero means polling only.
// - Mode bits 5:4 are writable only while write protect is disabled.
// - Edge/level bits 3:2 are writable only while write protect is disabled.
// - Bits 1 and 0 read as zero.
// - The value holds the capture in input mode, the match otherwise.
// - In capture modes one byte read latches both until the other is read.
// - Any status/control write resets the read latch, even in halt.
// - Value writes are ignored in input modes.
// - In halt the read latch keeps its state.
// - In halt value reads return live contents.
// - Output-mode value writes go through a coherent write buffer.
// - With enhanced features off, a status/control write resets the write latch.
// - In halt the write latch keeps its state.
// - In halt value writes go straight to the register.
// - Halt writes do not disturb a pending pair; the pair loads buffered bytes.
// - Edge/level code zero leaves the pin unused.
// - Compare mode codes 1, 2, 3 toggle, clear or set the output on match.
module tcv_channel (
	input wire logic clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [15:0] counterValue,
	input wire logic channelPin,
	input wire logic haltIn,
	output logic channelIrq,
	output logic channelOut,
	output logic pinUsed
);

	// ------------------------------------------------------------------
	// State.
	// ------------------------------------------------------------------
	typedef struct packed {
		logic flag;
		logic flagSeen;
		logic irqEn;
		logic [1:0] modeSel;
		logic [1:0] edgeSel;
		logic wpDisable;
		logic featEn;
		logic capTest;
		logic decapEn;
		logic [15:0] value;
		logic [15:0] readBuf;
		tcv_pkg::tcv_pair_t readPair;
		logic [15:0] writeBuf;
		tcv_pkg::tcv_pair_t writePair;
		logic bufPending;
		logic pinLast;
		logic out;
		logic [31:0] rdata;
		logic ready;
		logic err;
		logic irq;
		logic used;
	} tcv_state_t;

	tcv_state_t state_reg;
	tcv_state_t state_next;
	logic pinSync;
	logic haltSync;

	// ------------------------------------------------------------------
	// Pin and halt synchronisers.
	// ------------------------------------------------------------------
	tcv_pin_sync u_pin_sync (
		.clk(clk),
		.rst(rst),
		.pinIn(channelPin),
		.pinOut(pinSync)
	);

	tcv_pin_sync u_halt_sync (
		.clk(clk),
		.rst(rst),
		.pinIn(haltIn),
		.pinOut(haltSync)
	);

	// Input capture, capture test and dual edge modes count as input modes.
	function automatic logic is_input(input logic [1:0] ms, input logic ct, input logic de);
		is_input = (ms == `TCV_MS_INPUT) || ct || de;
	endfunction

	// Pair state update: the first byte opens the pair, the other closes it.
	function automatic tcv_pkg::tcv_pair_t pair_step(input tcv_pkg::tcv_pair_t p,
			input logic isHigh);
		if (p == tcv_pkg::TCV_IDLE) begin
			pair_step = isHigh ? tcv_pkg::TCV_HIGH : tcv_pkg::TCV_LOW;
		end else if ((p == tcv_pkg::TCV_HIGH) != isHigh) begin
			pair_step = tcv_pkg::TCV_IDLE;
		end else begin
			pair_step = p;
		end
	endfunction

	// ------------------------------------------------------------------
	// Next-state logic.
	// ------------------------------------------------------------------
	logic access;
	logic wr;
	logic rd;
	logic event_;
	logic inMode;
	logic edgeRise;
	logic edgeFall;
	logic match;
	logic [7:0] scRead;
	logic [7:0] byteW;

	// Channel function, bus access and coherency latches in one process.
	always_comb begin
		state_next = state_reg;
		access = psel && penable && !state_reg.ready;
		wr = access && pwrite;
		rd = access && !pwrite;
		byteW = pwdata[7:0];
		inMode = is_input(state_reg.modeSel, state_reg.capTest, state_reg.decapEn);
		edgeRise = pinSync && !state_reg.pinLast;
		edgeFall = !pinSync && state_reg.pinLast;
		match = counterValue == state_reg.value;
		event_ = 1'b0;
		state_next.pinLast = pinSync;
		state_next.used = state_reg.edgeSel != `TCV_ELS_OFF;
		// Capture or compare; an idle edge code disables both.
		if (state_reg.edgeSel != `TCV_ELS_OFF) begin
			if (inMode) begin
				if ((edgeRise && state_reg.edgeSel[0]) || (edgeFall && state_reg.edgeSel[1])) begin
					state_next.value = counterValue;
					event_ = 1'b1;
				end
			end else if (match) begin
				event_ = 1'b1;
				if (state_reg.modeSel == `TCV_MS_COMPARE) begin
					case (state_reg.edgeSel)
						`TCV_ELS_TOGGLE: state_next.out = !state_reg.out;
						`TCV_ELS_CLEAR: state_next.out = 1'b0;
						`TCV_ELS_SET: state_next.out = 1'b1;
						default: state_next.out = state_reg.out;
					endcase
				end
			end
		end
		// Write-buffer transfer at the update point, only for a completed pair.
		// The pending bit keeps a stale buffer from overwriting values written in halt.
		if (!inMode && !haltSync && state_reg.bufPending
				&& state_reg.writePair == tcv_pkg::TCV_IDLE
				&& counterValue == `TCV_UPDATE_POINT) begin
			state_next.value = state_reg.writeBuf;
			state_next.bufPending = 1'b0;
		end
		state_next.ready = access;
		state_next.err = 1'b0;
		state_next.rdata = 32'h0000_0000;
		scRead = {state_reg.flag, state_reg.irqEn, state_reg.modeSel, state_reg.edgeSel, 2'h0};
		if (rd) begin
			case (paddr)
				`TCV_ADDR_SC: begin
					state_next.rdata = {24'h000000, scRead};
					state_next.flagSeen = state_reg.flag;
				end
				`TCV_ADDR_VH, `TCV_ADDR_VL: begin
					if (haltSync) begin
						state_next.rdata = (paddr == `TCV_ADDR_VH) ? {24'h0, state_reg.value[15:8]}
							: {24'h0, state_reg.value[7:0]};
					end else if (inMode) begin
						// Latch both bytes on the first read of a pair.
						if (state_reg.readPair == tcv_pkg::TCV_IDLE) begin
							state_next.readBuf = state_reg.value;
							state_next.rdata = (paddr == `TCV_ADDR_VH) ? {24'h0, state_reg.value[15:8]}
								: {24'h0, state_reg.value[7:0]};
						end else begin
							state_next.rdata = (paddr == `TCV_ADDR_VH)
								? {24'h0, state_reg.readBuf[15:8]} : {24'h0, state_reg.readBuf[7:0]};
						end
						state_next.readPair = pair_step(state_reg.readPair, paddr == `TCV_ADDR_VH);
					end else begin
						state_next.rdata = (paddr == `TCV_ADDR_VH) ? {24'h0, state_reg.value[15:8]}
							: {24'h0, state_reg.value[7:0]};
					end
				end
				`TCV_ADDR_MODE: state_next.rdata = {27'h0, state_reg.decapEn, state_reg.capTest,
					haltSync, state_reg.featEn, state_reg.wpDisable};
				`TCV_ADDR_OUT: state_next.rdata = {30'h0, state_reg.used, state_reg.out};
				default: state_next.err = 1'b1;
			endcase
		end
		if (wr) begin
			case (paddr)
				`TCV_ADDR_SC: begin
					state_next.irqEn = byteW[`TCV_SC_IE];
					if (state_reg.wpDisable) begin
						state_next.modeSel = byteW[`TCV_SC_MSB:`TCV_SC_MSA];
						state_next.edgeSel = byteW[`TCV_SC_EDGE_LEVEL_SEL_HI:`TCV_SC_EDGE_LEVEL_SEL_LO];
					end
					// Zero clears only after a qualifying read and with no new event.
					if (!byteW[`TCV_SC_FLAG] && state_reg.flagSeen && !event_) begin
						state_next.flag = 1'b0;
					end
					state_next.flagSeen = 1'b0;
					state_next.readPair = tcv_pkg::TCV_IDLE;
					if (!state_reg.featEn) begin
						state_next.writePair = tcv_pkg::TCV_IDLE;
					end
				end
				`TCV_ADDR_VH, `TCV_ADDR_VL: begin
					if (!inMode) begin
						if (haltSync) begin
							if (paddr == `TCV_ADDR_VH) begin
								state_next.value[15:8] = byteW;
							end else begin
								state_next.value[7:0] = byteW;
							end
						end else begin
							if (paddr == `TCV_ADDR_VH) begin
								state_next.writeBuf[15:8] = byteW;
							end else begin
								state_next.writeBuf[7:0] = byteW;
							end
							state_next.writePair = pair_step(state_reg.writePair,
								paddr == `TCV_ADDR_VH);
							// Only the byte that closes a pair arms the update.
							if (state_next.writePair == tcv_pkg::TCV_IDLE) begin
								state_next.bufPending = 1'b1;
							end
						end
					end
				end
				`TCV_ADDR_MODE: begin
					state_next.wpDisable = byteW[`TCV_MODE_WRITE_PROTECT_DISABLE];
					state_next.featEn = byteW[`TCV_MODE_FEN];
					state_next.capTest = byteW[`TCV_MODE_CAPTEST];
					state_next.decapEn = byteW[`TCV_MODE_DECAP];
				end
				`TCV_ADDR_OUT: state_next.err = 1'b0;
				default: state_next.err = 1'b1;
			endcase
		end
		// A new event always wins over a clear in the same cycle.
		// An event also voids an earlier qualifying read, so a later zero write is ignored.
		if (event_) begin
			state_next.flag = 1'b1;
			state_next.flagSeen = 1'b0;
		end
		state_next.irq = state_next.flag && state_next.irqEn;
	end

	// ------------------------------------------------------------------
	// State register.
	// ------------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_reg <= '0;
			state_reg.readPair <= tcv_pkg::TCV_IDLE;
			state_reg.writePair <= tcv_pkg::TCV_IDLE;
			state_reg.wpDisable <= `TCV_WRITE_PROTECT_DISABLE_RESET;
		end else begin
			state_reg <= state_next;
		end
	end

	assign prdata = state_reg.rdata;
	assign pready = state_reg.ready;
	assign pslverr = state_reg.err;
	assign channelIrq = state_reg.irq;
	assign channelOut = state_reg.out;
	assign pinUsed = state_reg.used;

	// ------------------------------------------------------------------
	// Checks.
	// ------------------------------------------------------------------
	chk_irq_gate: assert property (@(posedge clk) disable iff (rst)
		channelIrq |-> ($past(state_next.flag) && $past(state_next.irqEn)))
		else $error("Interrupt without flag and enable.");
	chk_one_no_clear: assert property (@(posedge clk) disable iff (rst)
		(wr && paddr == `TCV_ADDR_SC && pwdata[`TCV_SC_FLAG] && state_reg.flag) |=> state_reg.flag)
		else $error("Writing one cleared the flag.");
	chk_clear_needs_read: assert property (@(posedge clk) disable iff (rst)
		(state_reg.flag && !state_reg.flagSeen) |=> state_reg.flag)
		else $error("Flag cleared without a prior read.");
	chk_event_wins: assert property (@(posedge clk) disable iff (rst)
		event_ |=> state_reg.flag)
		else $error("Event lost during clear.");
	chk_res_zero: assert property (@(posedge clk) disable iff (rst)
		(rd && paddr == `TCV_ADDR_SC) |=> (prdata[1:0] == 2'h0 && pready))
		else $error("Reserved bits not zero.");
	chk_wp_mode: assert property (@(posedge clk) disable iff (rst)
		(wr && paddr == `TCV_ADDR_SC && !state_reg.wpDisable) |=> $stable(state_reg.modeSel))
		else $error("Protected mode bits changed.");
	chk_wp_edge: assert property (@(posedge clk) disable iff (rst)
		(wr && paddr == `TCV_ADDR_SC && !state_reg.wpDisable) |=> $stable(state_reg.edgeSel))
		else $error("Protected edge bits changed.");
	chk_sc_read_unlatch: assert property (@(posedge clk) disable iff (rst)
		(wr && paddr == `TCV_ADDR_SC) |=> state_reg.readPair == tcv_pkg::TCV_IDLE)
		else $error("Read latch not reset.");
	chk_halt_rlatch: assert property (@(posedge clk) disable iff (rst)
		(haltSync && rd) |=> $stable(state_reg.readPair))
		else $error("Read latch moved in halt.");
	chk_halt_wlatch: assert property (@(posedge clk) disable iff (rst)
		(haltSync && wr && paddr != `TCV_ADDR_SC) |=> $stable(state_reg.writePair))
		else $error("Write latch moved in halt.");
	chk_input_nowrite: assert property (@(posedge clk) disable iff (rst)
		(inMode && wr && paddr == `TCV_ADDR_VH) |=> $stable(state_reg.writeBuf))
		else $error("Value written in input mode.");
	chk_pin_off: assert property (@(posedge clk) disable iff (rst)
		(state_reg.edgeSel == `TCV_ELS_OFF) |-> (!event_ ##1 !pinUsed))
		else $error("Pin used while disabled.");
	chk_late_event: assert property (@(posedge clk) disable iff (rst)
		event_ |=> !state_reg.flagSeen)
		else $error("Event did not void the clearing read.");
	chk_sc_wunlatch: assert property (@(posedge clk) disable iff (rst)
		(wr && paddr == `TCV_ADDR_SC && !state_reg.featEn) |=>
			state_reg.writePair == tcv_pkg::TCV_IDLE)
		else $error("Write latch not reset.");
	chk_capture_value: assert property (@(posedge clk) disable iff (rst)
		(inMode && event_) |=> state_reg.value == $past(counterValue))
		else $error("Capture did not store the counter.");
	chk_halt_direct: assert property (@(posedge clk) disable iff (rst)
		(haltSync && !inMode && wr && paddr == `TCV_ADDR_VL) |=>
			state_reg.value[7:0] == $past(pwdata[7:0]))
		else $error("Halt write did not reach the value.");
	// Cover the main scenarios: capture, clear, halt write, late event, buffered update.
	cov_capture: cover property (@(posedge clk) disable iff (rst) inMode && event_);
	cov_clear: cover property (@(posedge clk) disable iff (rst) $fell(state_reg.flag));
	cov_halt_write: cover property (@(posedge clk) disable iff (rst) haltSync && wr);
	cov_late_event: cover property (@(posedge clk) disable iff (rst) event_ && state_reg.flagSeen);
	cov_pair_update: cover property (@(posedge clk) disable iff (rst) $fell(state_reg.bufPending));

endmodule // tcv_channel

//--- tb/tb_top.sv
`timescale 1ns/1ps
`include "tcv_params.svh"

module tb_top;
	logic clk;
	logic rst;
	logic psel;
	logic penable;
	logic pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [15:0] counterValue;
	logic channelPin;
	logic haltIn;
	logic channelIrq;
	logic channelOut;
	logic pinUsed;
	int numErrors = 0;
	int compares = 0;
	logic [31:0] rd;
	logic err;

	tcv_channel tcv_channel_i (
		.clk(clk),
		.rst(rst),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.counterValue(counterValue),
		.channelPin(channelPin),
		.haltIn(haltIn),
		.channelIrq(channelIrq),
		.channelOut(channelOut),
		.pinUsed(pinUsed)
	);

	// Free-running 40 MHz clock.
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------

	// Prints the counts and the verdict, then stops.
	task automatic endOfTest();
		$display("compares %0d mismatches %0d", compares, numErrors);
		if (numErrors == 0 && compares > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// Case equality, so an unknown never counts as a match.
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			numErrors++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// One APB transfer; the request is held until pready is seen high at an edge.
	task automatic apbXfer(input logic wr, input logic [11:0] addr, input logic [7:0] data,
			output logic [31:0] rdata, output logic slvErr);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= addr;
		pwdata <= {24'h0, data};
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (pready !== 1'b1) begin
			numErrors++;
			$display("MISMATCH pready expected 1 seen 0");
			endOfTest();
		end
		rdata = prdata;
		slvErr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] addr, input logic [7:0] data);
		apbXfer(1'b1, addr, data, rd, err);
	endtask

	task automatic rdChk(input string name, input logic [11:0] addr, input logic [7:0] exp);
		apbXfer(1'b0, addr, 8'h00, rd, err);
		check(name, rd, {24'h0, exp});
	endtask

	task automatic waitClk(input int n);
		repeat (n) @(posedge clk);
	endtask

	// A one-cycle counter value, then back to a value that matches nothing.
	task automatic pulse(input logic [15:0] v);
		@(posedge clk);
		counterValue <= v;
		@(posedge clk);
		counterValue <= 16'h0100;
		waitClk(4);
	endtask

	// Rising then falling pin edge; the wait covers the three-flop synchroniser.
	task automatic capture(input logic [15:0] v);
		@(posedge clk);
		counterValue <= v;
		channelPin <= 1'b1;
		waitClk(8);
		channelPin <= 1'b0;
		waitClk(8);
	endtask

	task automatic halt(input logic b);
		@(posedge clk);
		haltIn <= b;
		waitClk(8);
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------

	task automatic testReset();
		rdChk("sc", `TCV_ADDR_SC, 8'h00);
		rdChk("mode", `TCV_ADDR_MODE, 8'h01);
		rdChk("out", `TCV_ADDR_OUT, 8'h00);
		apbXfer(1'b0, 12'h020, 8'h00, rd, err);
		check("slverr", {31'h0, err}, 32'h1);
		$display("test reset done");
	endtask

	task automatic testProtect();
		wr(`TCV_ADDR_MODE, 8'h00);
		wr(`TCV_ADDR_SC, 8'h3c);
		rdChk("sc locked", `TCV_ADDR_SC, 8'h00);
		wr(`TCV_ADDR_MODE, 8'h01);
		wr(`TCV_ADDR_SC, 8'h1f);
		rdChk("sc open", `TCV_ADDR_SC, 8'h1c);
		check("used", {31'h0, pinUsed}, 32'h1);
		wr(`TCV_ADDR_SC, 8'h10);
		waitClk(2);
		check("unused", {31'h0, pinUsed}, 32'h0);
		$display("test protect done");
	endtask

	// Clear, set, toggle, toggle: each step leaves a different output level.
	task automatic testCompare();
		logic [7:0] code [4];
		logic outExp [4];
		code = '{8'h18, 8'h1c, 8'h14, 8'h14};
		outExp = '{1'b0, 1'b1, 1'b0, 1'b1};
		wr(`TCV_ADDR_SC, 8'h1c);
		wr(`TCV_ADDR_VH, 8'h12);
		wr(`TCV_ADDR_VL, 8'h34);
		pulse(16'h0000);
		rdChk("vh", `TCV_ADDR_VH, 8'h12);
		rdChk("vl", `TCV_ADDR_VL, 8'h34);
		for (int i = 0; i < 4; i++) begin
			wr(`TCV_ADDR_SC, code[i]);
			pulse(16'h1234);
			check("out", {31'h0, channelOut}, {31'h0, outExp[i]});
		end
		check("irq off", {31'h0, channelIrq}, 32'h0);
		$display("test compare done");
	endtask

	task automatic testFlag();
		wr(`TCV_ADDR_SC, 8'h54);
		rdChk("no read", `TCV_ADDR_SC, 8'hd4);
		check("irq on", {31'h0, channelIrq}, 32'h1);
		wr(`TCV_ADDR_SC, 8'hd4);
		rdChk("write one", `TCV_ADDR_SC, 8'hd4);
		pulse(16'h1234);
		wr(`TCV_ADDR_SC, 8'h54);
		rdChk("late event", `TCV_ADDR_SC, 8'hd4);
		wr(`TCV_ADDR_SC, 8'h54);
		rdChk("cleared", `TCV_ADDR_SC, 8'h54);
		check("irq clr", {31'h0, channelIrq}, 32'h0);
		pulse(16'h1234);
		wr(`TCV_ADDR_SC, 8'h14);
		rdChk("set", `TCV_ADDR_SC, 8'h94);
		check("irq mask", {31'h0, channelIrq}, 32'h0);
		$display("test flag done");
	endtask

	// A pair opened before halt must survive halt writes and close afterwards.
	task automatic testHalt();
		wr(`TCV_ADDR_VH, 8'haa);
		halt(1'b1);
		rdChk("mode halt", `TCV_ADDR_MODE, 8'h05);
		wr(`TCV_ADDR_VH, 8'h55);
		wr(`TCV_ADDR_VL, 8'h66);
		rdChk("vh direct", `TCV_ADDR_VH, 8'h55);
		rdChk("vl direct", `TCV_ADDR_VL, 8'h66);
		halt(1'b0);
		wr(`TCV_ADDR_VL, 8'hbb);
		pulse(16'h0000);
		rdChk("vh pair", `TCV_ADDR_VH, 8'haa);
		rdChk("vl pair", `TCV_ADDR_VL, 8'hbb);
		// A status/control write with enhanced features off drops the open pair.
		wr(`TCV_ADDR_VH, 8'h11);
		wr(`TCV_ADDR_SC, 8'h14);
		wr(`TCV_ADDR_VL, 8'h22);
		pulse(16'h0000);
		rdChk("vh unlatched", `TCV_ADDR_VH, 8'haa);
		$display("test halt done");
	endtask

	task automatic testCapture();
		wr(`TCV_ADDR_SC, 8'h04);
		rdChk("sc idle", `TCV_ADDR_SC, 8'h04);
		capture(16'habcd);
		rdChk("sc cap", `TCV_ADDR_SC, 8'h84);
		rdChk("vh cap", `TCV_ADDR_VH, 8'hab);
		capture(16'h5678);
		rdChk("vl held", `TCV_ADDR_VL, 8'hcd);
		rdChk("vh new", `TCV_ADDR_VH, 8'h56);
		capture(16'h9abc);
		wr(`TCV_ADDR_VH, 8'hff);
		wr(`TCV_ADDR_SC, 8'h04);
		rdChk("vl unlatch", `TCV_ADDR_VL, 8'hbc);
		rdChk("vh nowrite", `TCV_ADDR_VH, 8'h9a);
		rdChk("vh latch", `TCV_ADDR_VH, 8'h9a);
		capture(16'h1111);
		halt(1'b1);
		rdChk("vl live", `TCV_ADDR_VL, 8'h11);
		halt(1'b0);
		rdChk("vl frozen", `TCV_ADDR_VL, 8'hbc);
		$display("test capture done");
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------

	// Every input has a value at time zero; reset spans four edges.
	initial begin
		rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		counterValue = 16'h0100;
		channelPin = 1'b0;
		haltIn = 1'b0;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		testReset();
		testProtect();
		testCompare();
		testFlag();
		testHalt();
		testCapture();
		endOfTest();
	end
endmodule // tb_top
